/* File: core/logic_equation_bank.sv */
// Bank of cascadable logic equations behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
module logic_equation_bank
   import logic_equation_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [EXT_W-1:0]  ext_signals,
   output logic [EQ_COUNT-1:0]    eq_out,
   output logic [EQ_COUNT-1:0]    eq_latched,
   output logic [EQ_COUNT-1:0]    eq_latched_n,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready
);
   logic [31:0]          cfg [EQ_COUNT];
   logic [31:0]          dly [EQ_COUNT];
   logic [CNT_W-1:0]     cnt [EQ_COUNT];
   logic [3:0]           cond [EQ_COUNT];
   logic [IDX_W-1:0]     eval_idx;
   logic [EXT_W-1:0]     sync1, sync2, sync3, ext_q;
   logic [ADDR_W-1:0]    aw_addr_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 aw_got, w_got;

   // Pins settle through three stages; accept once the last two agree
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         ext_q <= '0;
      end else begin
         sync1 <= ext_signals;
         sync2 <= sync1;
         sync3 <= sync2;
         for (int b = 0; b < EXT_W; b++) begin
            if (sync2[b] == sync3[b]) begin
               ext_q[b] <= sync3[b];
            end
         end
      end
   end

   // Signal list; outputs come from the stored flops, so a lower
   // equation already holds this pass's value, a higher one the last
   wire [31:0] sig_vec = {eq_latched, eq_out,
                          ext_q, 1'h0};

   // Decode of the equation under evaluation
   wire [31:0]      cur_cfg  = cfg[eval_idx];
   wire [31:0]      cur_dly  = dly[eval_idx];
   wire [CNT_W-1:0] cur_cnt  = cnt[eval_idx];
   wire             cur_out  = eq_out[eval_idx];
   wire             cur_lat  = eq_latched[eval_idx];
   wire [3:0]       raw_in;
   for (genvar k = 0; k < 4; k++) begin : g_pick
      assign raw_in[k] = sig_vec[cur_cfg[CFG_SEL0+SEL_W*k +: SEL_W]];
   end
   wire [3:0] cond_in = raw_in ^ cur_cfg[CFG_INV +: 4];
   wire gate_and = &cond_in;
   wire gate_or  = |cond_in;
   wire [1:0] gate_sel = cur_cfg[CFG_GATE +: 2];
   wire gate_res = (gate_sel == GATE_AND)  ? gate_and :
                   (gate_sel == GATE_OR)   ? gate_or :
                   (gate_sel == GATE_NAND) ? ~gate_and : ~gate_or;
   wire [SEL_W-1:0] rst_sel = cur_cfg[CFG_RSEL +: SEL_W];
   // Select 0 is tied low, so an unassigned reset never clears unless its invert bit is set
   wire rst_cond = sig_vec[rst_sel] ^ cur_cfg[CFG_RINV];

   // Timer: output follows the gate after the delay has run out
   wire [CNT_W-1:0] limit = gate_res ? cur_dly[DLY_RISE +: CNT_W]
                                     : cur_dly[DLY_FALL +: CNT_W];
   wire agree      = (gate_res == cur_out);
   wire expired    = (cur_cnt >= limit);
   wire next_out   = (!agree && expired) ? gate_res : cur_out;
   wire [CNT_W-1:0] next_cnt = (agree || expired) ? '0
                                 : cur_cnt + CNT_W'(1);
   // Reset dominant latch, set by the delayed result
   wire next_lat   = !rst_cond && (cur_lat || next_out);
   wire [IDX_W-1:0] next_idx = (eval_idx == IDX_W'(EQ_COUNT-1)) ? '0
                                 : eval_idx + IDX_W'(1);

   // One equation per clock, ascending, wrapping forever
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         eval_idx     <= '0;
         eq_out       <= '0;
         eq_latched   <= '0;
         eq_latched_n <= '1;
         for (int i = 0; i < EQ_COUNT; i++) begin
            cnt[i]  <= '0;
            cond[i] <= '0;
         end
      end else begin
         eval_idx                <= next_idx;
         eq_out[eval_idx]        <= next_out;
         eq_latched[eval_idx]    <= next_lat;
         eq_latched_n[eval_idx]  <= ~next_lat;
         cnt[eval_idx]           <= next_cnt;
         cond[eval_idx]          <= cond_in;
      end
   end

   // Write decode on the held address
   wire aw_cfg  = aw_addr_q[ADDR_W-1:5] == OFS_CFG[ADDR_W-1:5];
   wire aw_dly  = aw_addr_q[ADDR_W-1:5] == OFS_DLY[ADDR_W-1:5];
   wire aw_ok   = (aw_cfg || aw_dly) && (aw_addr_q[1:0] == 2'h0);
   wire [IDX_W-1:0] aw_idx = aw_addr_q[2 +: IDX_W];
   wire do_write = aw_got && w_got && !bvalid;
   wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                            {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire [31:0] old_word = aw_cfg ? cfg[aw_idx] : dly[aw_idx];
   wire [31:0] new_word = (old_word & ~strb_mask) | (w_data_q & strb_mask);

   // Address and data taken in either order; answer when both held
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
         for (int i = 0; i < EQ_COUNT; i++) begin
            cfg[i] <= CFG_RESET;
            dly[i] <= DLY_RESET;
         end
      end else begin
         awready <= awvalid && !awready && !aw_got;
         wready  <= wvalid && !wready && !w_got;
         if (awvalid && awready) begin
            aw_got    <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_got    <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= aw_ok ? RESP_OKAY : RESP_SLVERR;
            if (aw_ok && aw_cfg) begin
               cfg[aw_idx] <= new_word;
            end
            if (aw_ok && aw_dly) begin
               dly[aw_idx] <= new_word;
            end
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got  <= 1'b0;
         end
      end
   end

   // Read decode; status words show live equation state
   wire [IDX_W-1:0] ar_idx = araddr[2 +: IDX_W];
   wire ar_cfg  = araddr[ADDR_W-1:5] == OFS_CFG[ADDR_W-1:5];
   wire ar_dly  = araddr[ADDR_W-1:5] == OFS_DLY[ADDR_W-1:5];
   wire [31:0] cond_word;
   for (genvar e = 0; e < EQ_COUNT; e++) begin : g_cond
      assign cond_word[4*e +: 4] = cond[e];
   end
   wire [31:0] status_word = {8'h00, eq_latched_n, eq_latched, eq_out};
   wire ar_hit = (araddr[1:0] == 2'h0) && (ar_cfg || ar_dly ||
                 araddr == OFS_STATUS || araddr == OFS_COND ||
                 araddr == OFS_EXT);
   wire [31:0] read_word =
      ar_cfg                 ? cfg[ar_idx] :
      ar_dly                 ? dly[ar_idx] :
      (araddr == OFS_STATUS) ? status_word :
      (araddr == OFS_COND)   ? cond_word :
      (araddr == OFS_EXT)    ? {17'h00000, ext_q} : 32'h0000_0000;

   // Single read in flight; unmapped gives zero and an error
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= ar_hit ? read_word : 32'h0000_0000;
            rresp  <= ar_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Checks on the evaluation engine and the bus answer
   logic [IDX_W-1:0] prev_idx;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prev_idx <= '0;
      end else begin
         prev_idx <= eval_idx;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_eval_reset;
      rst_cond;
   endsequence
   sequence s_eval_set;
      !rst_cond && next_out;
   endsequence
   sequence s_pass_end;
      eval_idx == IDX_W'(EQ_COUNT-1);
   endsequence

   chk_order_step: assert property (
      !(eval_idx == IDX_W'(EQ_COUNT-1)) |=>
         eval_idx == $past(eval_idx) + IDX_W'(1))
      else $error("equation order broken");
   chk_pass_wrap: assert property (
      s_pass_end |=> eval_idx == '0 ##7 s_pass_end)
      else $error("pass did not repeat");
   chk_reset_wins: assert property (
      s_eval_reset |=> !eq_latched[prev_idx])
      else $error("latch not cleared by reset");
   chk_latch_set: assert property (
      s_eval_set |=> eq_latched[prev_idx] && eq_out[prev_idx])
      else $error("latch not set by delayed result");
   chk_latch_inverse: assert property (
      eq_latched_n == ~eq_latched)
      else $error("inverted latch mismatch");
   chk_no_reset_hold: assert property (
      rst_sel == SEL_NONE && !cur_cfg[CFG_RINV] && cur_lat
         |=> eq_latched[prev_idx])
      else $error("latch cleared without reset signal");
   chk_zero_delay: assert property (
      !agree && limit == '0 |=> eq_out[prev_idx] == $past(gate_res))
      else $error("zero delay not immediate");
   chk_delay_hold: assert property (
      !agree && !expired |=> eq_out[prev_idx] == $past(cur_out))
      else $error("output changed before delay");
   chk_cond_invert: assert property (
      cur_cfg[CFG_INV +: 4] == 4'hF |-> cond_in == ~raw_in)
      else $error("input inversion wrong");
   chk_write_answer: assert property (
      aw_got && w_got && !bvalid |=> bvalid ##0 bvalid [*1])
      else $error("write answer missing");

   // Further checks on latch, timer, pin filter and read answer
   sequence s_latch_kept;
      !rst_cond && cur_lat;
   endsequence
   chk_latch_hold: assert property (
      s_latch_kept |=> eq_latched[prev_idx])
      else $error("latch dropped without reset");
   chk_out_follow: assert property (
      agree |=> eq_out[prev_idx] == $past(cur_out))
      else $error("output moved while gate agreed");
   chk_pin_filter: assert property (
      sync2 == sync3 |=> ext_q == $past(sync3))
      else $error("pin filter did not accept");
   chk_read_answer: assert property (
      arvalid && arready |=> rvalid && !arready)
      else $error("read answer missing");
endmodule
`default_nettype wire

/* File: core/logic_equation_pkg.sv */
// Constants and register map of the logic equation bank
package logic_equation_pkg;
   localparam int EQ_COUNT = 8;   // Equations in one pass
   localparam int IDX_W    = 3;
   localparam int EXT_W    = 15;  // Outside signals on pins
   localparam int SEL_W    = 5;   // Signal list select width
   localparam int CNT_W    = 16;  // Delay counter width
   localparam int ADDR_W   = 12;
   // Signal list: 0 none, 1..15 pins, 16..23 outputs, 24..31 latches
   localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;
   // Configuration word fields
   localparam int CFG_SEL0   = 0;   // Four 5-bit input selects
   localparam int CFG_INV    = 20;  // Four input invert bits
   localparam int CFG_GATE   = 24;  // Two-bit gate type
   localparam int CFG_RSEL   = 26;  // Latch reset select
   localparam int CFG_RINV   = 31;  // Latch reset invert
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // Delay word fields, counted in passes
   localparam int DLY_RISE = 0;
   localparam int DLY_FALL = 16;
   localparam logic [31:0] DLY_RESET = 32'h0000_0000;
   // Byte offsets
   localparam logic [ADDR_W-1:0] OFS_CFG    = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_DLY    = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h040;
   localparam logic [ADDR_W-1:0] OFS_COND   = 12'h044;
   localparam logic [ADDR_W-1:0] OFS_EXT    = 12'h048;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      GATE_AND, GATE_OR, GATE_NAND, GATE_NOR
   } gate_t;
endpackage

/* File: verification/field_side_model.sv */
// Far-side model: field contacts feeding the equation pins
`timescale 1ns/10ps
`default_nettype none
module field_side_model
   import logic_equation_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic [EXT_W-1:0] contact_req,
   output logic      [EXT_W-1:0] ext_signals
);
   // Contacts settle only after an edge, as a real input would
   always @(posedge ref_clk) begin
      ext_signals <= contact_req;
   end
endmodule
`default_nettype wire

/* File: verification/programmable_logic_equations_tb_top.sv */
// Self-checking bench for the logic equation bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module programmable_logic_equations_tb_top;
   import logic_equation_pkg::*;
   logic                ref_clk = 1'h0;
   logic                rst = 1'h1;
   logic [EXT_W-1:0]    pins = '0;
   logic [EXT_W-1:0]    ext_signals;
   logic [EQ_COUNT-1:0] eq_out, eq_latched, eq_latched_n;
   logic [ADDR_W-1:0]   awaddr = '0, araddr = '0;
   logic                awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic                arvalid = 1'h0, rready = 1'h0;
   logic [31:0]         wdata = '0, rd, rdata;
   logic [3:0]          wstrb = '0;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [1:0]          bresp, rresp, rsp;
   int                  compares = 0, mismatches = 0;

   // Clock of 5 ns
   always #2.5 ref_clk = ~ref_clk;

   field_side_model far_u (.ref_clk, .contact_req(pins), .ext_signals);
   logic_equation_bank dut_u (.ref_clk, .rst, .ext_signals, .eq_out,
      .eq_latched, .eq_latched_n, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic set_pins(input logic [EXT_W-1:0] v);
      @(posedge ref_clk);
      pins <= v;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge ref_clk);
         if (awready === 1'h1) begin
            awvalid <= 1'h0;
            aw_ok = 1'h1;
         end
         if (wready === 1'h1) begin
            wvalid <= 1'h0;
            w_ok = 1'h1;
         end
      end
      while (bvalid !== 1'h1) @(posedge ref_clk);
      bready <= 1'h0;
      rsp = bresp;
   endtask

   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      rd = rdata;
      rsp = rresp;
   endtask

   // Reference gate: only pin codes and the empty code are used here
   function automatic logic model(logic [31:0] c, logic [EXT_W-1:0] p);
      int hi, any;
      logic v;
      hi = 1;
      any = 0;
      for (int k = 0; k < 4; k++) begin
         v = (c[5*k +: 5] == 5'h00) ? 1'h0 : p[c[5*k +: 5] - 1];
         v = v ^ c[CFG_INV + k];
         hi = hi & v;
         any = any | v;
      end
      case (c[CFG_GATE +: 2])
         2'h0: model = hi[0];
         2'h1: model = any[0];
         2'h2: model = !hi[0];
         default: model = !any[0];
      endcase
   endfunction

   // Source drives equation 1; lag is clocks until equation 1 follows
   task automatic cascade(input int src, input int lag);
      int n;
      n = 0;
      wr(12'(OFS_CFG + 4 * src), 32'h0100_0006);
      wr(12'h004, 32'h0100_0010 + 32'(src));
      // Let stale outputs of the earlier setup drain first
      wait_cyc(24);
      set_pins(15'h0020);
      while (eq_out[src] !== 1'h1 && n < 60) begin
         wait_cyc(1);
         n++;
      end
      wait_cyc(lag - 1);
      `CHK(eq_out[1], 1'h0)
      wait_cyc(1);
      `CHK(eq_out[1], 1'h1)
      set_pins(15'h0000);
      wait_cyc(40);
   endtask

   task automatic give_verdict;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard, well past the expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      logic [31:0] c;
      void'($urandom(32'h1B351BF7));
      repeat (10) @(posedge ref_clk);
      rst <= 1'h0;
      rd_reg(OFS_DLY);
      `CHK(rd, DLY_RESET)
      rd_reg(OFS_STATUS);
      `CHK(rd, 32'h00FF_0000)
      rd_reg(12'hFFC);
      `CHK(rsp, RESP_SLVERR)
      wr(12'hFFC, 32'hFFFF_FFFF);
      `CHK(rsp, RESP_SLVERR)
      $display("done: registers");
      // Every gate type, random inversions and pin levels
      for (int g = 0; g < 4; g++) begin
         repeat (4) begin
            c = $urandom;
            c = {6'h00, g[1:0], c[3:0], 20'h20C41};
            wr(OFS_CFG, c);
            set_pins(15'($urandom));
            wait_cyc(40);
            `CHK(eq_out[0], model(c, pins))
         end
      end
      set_pins(15'h0000);
      $display("done: gates");
      cascade(0, 1);
      cascade(3, 6);
      $display("done: cascade");
      // Rise delay of two passes, fall delay of one
      wr(12'h008, 32'h0100_0007);
      wr(12'h028, 32'h0001_0002);
      rd_reg(12'h028);
      `CHK(rd, 32'h0001_0002)
      set_pins(15'h0040);
      // Pins settle after five clocks; a delay of one would show by now
      wait_cyc(21);
      `CHK(eq_out[2], 1'h0)
      wait_cyc(27);
      `CHK(eq_out[2], 1'h1)
      set_pins(15'h0000);
      // A zero fall delay would already have dropped here
      wait_cyc(13);
      `CHK(eq_out[2], 1'h1)
      wait_cyc(15);
      `CHK(eq_out[2], 1'h0)
      $display("done: timer");
      // Latch on equation 4, reset from pin code 9
      wr(12'h010, 32'h2500_0008);
      rd_reg(12'h010);
      `CHK(rd, 32'h2500_0008)
      set_pins(15'h0080);
      wait_cyc(24);
      set_pins(15'h0000);
      wait_cyc(24);
      `CHK(eq_out[4], 1'h0)
      `CHK(eq_latched[4], 1'h1)
      `CHK(eq_latched_n[4], 1'h0)
      rd_reg(OFS_STATUS);
      `CHK(rd, 32'h00E0_1F00)
      set_pins(15'h0180);
      wait_cyc(24);
      `CHK(eq_latched[4], 1'h0)
      set_pins(15'h0080);
      wait_cyc(24);
      `CHK(eq_latched[4], 1'h1)
      rd_reg(OFS_EXT);
      `CHK(rd, 32'h0000_0080)
      rd_reg(OFS_COND);
      `CHK(rd, 32'h0001_0000)
      set_pins(15'h0000);
      wr(12'h010, 32'hA500_0008);
      wait_cyc(24);
      `CHK(eq_latched[4], 1'h0)
      $display("done: latch");
      give_verdict();
   end
endmodule
`default_nettype wire
